// file: include/scsr_pkg.sv
`default_nettype none
package scsr_pkg;
  localparam logic [5:0] OFS_CONFIG   = 6'h00;
  localparam logic [5:0] OFS_STATUS   = 6'h04;
  localparam logic [5:0] OFS_MASK     = 6'h08;
  localparam logic [5:0] OFS_AGING    = 6'h0C;
  localparam logic [5:0] OFS_UNMATCH  = 6'h10;
  localparam logic [5:0] OFS_TX_RINGS = 6'h14;
  localparam logic [5:0] OFS_RX_RINGS = 6'h18;
  localparam logic [5:0] OFS_SW_RESET = 6'h38;

  localparam int CFG_AGING_EN   = 0;
  localparam int CFG_GRAN       = 1;
  localparam int CFG_ORDER_LO   = 2;
  localparam int CFG_RX_EN      = 4;
  localparam int CFG_TX_EN      = 5;
  localparam int CFG_SMALL_MAP  = 6;
  localparam int CFG_WIDTH      = 14;
  localparam logic [13:0] CFG_RESET = 14'h0000;
  localparam logic [1:0] ORDER_LITTLE = 2'h0;
  localparam logic [1:0] ORDER_BIG    = 2'h1;

  localparam int ST_TX_DONE   = 0;
  localparam int ST_SENT_WRAP = 1;
  localparam int ST_RCVD_WRAP = 2;
  localparam int ST_DISC_WRAP = 3;
  localparam int ST_PROT_WRAP = 4;
  localparam int ST_HDR_WRAP  = 5;
  localparam int ST_UNMATCH   = 6;
  localparam int ST_RX_DONE   = 7;
  localparam int ST_TRANSMIT_FREEZE    = 8;
  localparam int ST_RECEIVE_FREEZE    = 9;
  localparam int ST_BUS64     = 10;
  localparam int ST_EVENTS    = 10;
  localparam logic [31:0] MASK_IMPL = 32'hFFFF03FF;

  localparam int UH_VALID   = 28;
  localparam logic [27:0] UH_FIELD_MASK = 28'hFFFFC00;
  localparam int TX_RING_W  = 13;
  localparam int RX_RING_W  = 10;
  localparam int AGING_CNT_W = 15;
  localparam int RST_SYNC_STAGES = 2;
  localparam logic [3:0] SW_RESET_CYCLES = 4'hA;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [5:0] addr;
    logic [31:0] wdata;
  } scsr_bus_req_t;

  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_overflow;
    logic rx_overflow;
    logic hdr_err_wrap;
    logic protocol_wrap;
    logic discard_wrap;
    logic rcvd_wrap;
    logic sent_wrap;
  } scsr_events_t;
endpackage
`default_nettype wire

// file: hw/scsr_ring_ptr.sv
`timescale 1ns/1ps
`default_nettype none
module scsr_ring_ptr
  import scsr_pkg::*;
#(
  parameter int W = 13
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         advance,
  input  wire logic [W-1:0] size_code,
  output logic      [W-1:0] ptr
);
  initial
  begin
    if (W < 1 || W > 16) $error("scsr_ring_ptr: bad width");
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ptr <= '0;
    else if (ce && advance)
    begin
      if (ptr == size_code)
        ptr <= '0;
      else
        ptr <= ptr + W'(1);
    end
  end
endmodule // scsr_ring_ptr
`default_nettype wire

// file: hw/scsr_aging_timer.sv
`timescale 1ns/1ps
`default_nettype none
module scsr_aging_timer
  import scsr_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   enable,
  input  wire logic [15:0]            reload,
  input  wire logic [AGING_CNT_W-1:0] cycle_limit,
  output logic                        expire,
  output logic      [AGING_CNT_W-1:0] channel
);
  logic [15:0] count;

  // The count reloads while disabled so a fresh enable always waits a full period.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count  <= '0;
      expire <= 1'b0;
    end
    else if (ce)
    begin
      expire <= 1'b0;
      if (!enable)
        count <= reload;
      else if (count == 16'h0000)
      begin
        count  <= reload;
        expire <= 1'b1;
      end
      else
        count <= count - 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      channel <= '0;
    else if (ce && expire)
    begin
      if (channel >= cycle_limit)
        channel <= '0;
      else
        channel <= channel + AGING_CNT_W'(1);
    end
  end
endmodule // scsr_aging_timer
`default_nettype wire

// file: hw/scsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Small map ORs address bit 14 down.
// - Transmit disable stops fetch, drains buffer.
// - Transmit enable resets low, freeze clears.
// - Receive disable drops all arriving cells.
// - Receive enable resets low, freeze clears.
// - Byte order 00 little, 01 big.
// - Granularity picks per-packet or per-buffer transmit done pulses.
// - Aging enable low stops all aging.
// - Status read clears low ten bits.
// - Ring overflows set freeze status bits.
// - Completions set receive and transmit done.
// - Header capture sets unmatched status bit.
// - Five counter wraps set status bits.
// - Bit 10 bus width, top mirrors bus.
// - Interrupt when masked status bit set.
// - Aging timer reloads, visits channels round robin.
// - Unmatched cells captured into header register.
// - Capture holds first value, clears on read.
// - Ring pointers wrap after size code.
module scsr_regs
  import scsr_pkg::*;
#(
  parameter int CM_ADDR_W = 15
)(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire scsr_bus_req_t          bus_req,
  output logic      [31:0]            bus_rdata,
  input  wire logic                   bus64_strap,
  input  wire logic [15:0]            bus_status,
  input  wire scsr_events_t           events,
  input  wire logic                   tx_packet_end,
  input  wire logic                   unmatched_valid,
  input  wire logic                   path_disabled,
  input  wire logic                   out_of_range,
  input  wire logic                   chan_off,
  input  wire logic [27:0]            unmatched_hdr,
  input  wire logic [CM_ADDR_W-1:0]   cm_addr_in,
  input  wire logic                   host_fetch_req,
  input  wire logic                   cell_arrive,
  input  wire logic                   tx_ring_quiet_adv,
  input  wire logic                   tx_ring_irq_adv,
  input  wire logic                   rx_ring_quiet_adv,
  input  wire logic                   rx_ring_irq_adv,
  output logic      [CM_ADDR_W-1:0]   control_memory_address,
  output logic                        host_fetch_grant,
  output logic                        cell_accept,
  output logic                        big_endian,
  output logic                        tx_done_irq_pulse,
  output logic                        aging_tick,
  output logic      [AGING_CNT_W-1:0] aging_channel,
  output logic      [TX_RING_W-1:0]   tx_quiet_ptr,
  output logic      [TX_RING_W-1:0]   tx_irq_ptr,
  output logic      [RX_RING_W-1:0]   rx_quiet_ptr,
  output logic      [RX_RING_W-1:0]   rx_irq_ptr,
  output logic                        irq
);
  initial
  begin
    if (CM_ADDR_W != 15) $error("scsr_regs: control memory address must be 15 bits");
  end

  logic [RST_SYNC_STAGES-1:0] rst_sync;
  logic                       rst_n;
  logic [3:0]                 sw_rst_cnt;
  logic                       sw_rst_active;
  logic [CFG_WIDTH-1:0]       config_reg;
  logic [ST_EVENTS-1:0]       event_status;
  logic [15:0]                pci_status;
  logic                       bus64_latched;
  logic                       strap_taken;
  logic [1:0]                 strap_sync;
  logic [1:0]                 strap_fill;
  logic [31:0]                event_mask;
  logic [15:0]                aging_reload_value;
  logic [15:0]                aging_cycle_limit;
  logic [28:0]                unmatched_header_capture;
  logic [15:0]                tx_done_ring_quiet_size;
  logic [15:0]                tx_done_ring_irq_size;
  logic [15:0]                rx_done_ring_quiet_size;
  logic [15:0]                rx_done_ring_irq_size;
  logic [31:0]                status_word;
  logic [31:0]                next_rdata;
  logic                       wr_hit;
  logic                       rd_hit;
  logic                       status_read;
  logic                       unmatch_read;
  logic                       capture;
  logic                       aging_expire;
  logic [AGING_CNT_W-1:0]     aging_chan_q;
  logic [ST_EVENTS-1:0]       set_bits;

  // Hardware reset is released through two flops; the software reset
  // extends it for a fixed count of cycles.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= '0;
    else
      rst_sync <= {rst_sync[RST_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sw_rst_cnt <= 4'h0;
    else if (clk_en && bus_req.sel && bus_req.wr && bus_req.addr == OFS_SW_RESET)
      sw_rst_cnt <= SW_RESET_CYCLES;
    else if (sw_rst_cnt != 4'h0)
      sw_rst_cnt <= sw_rst_cnt - 4'h1;
  end

  assign sw_rst_active = (sw_rst_cnt != 4'h0);
  assign rst_n = rst_sync[RST_SYNC_STAGES-1] && !sw_rst_active;

  assign wr_hit       = clk_en && bus_req.sel && bus_req.wr;
  assign rd_hit       = clk_en && bus_req.sel && !bus_req.wr;
  assign status_read  = rd_hit && bus_req.addr == OFS_STATUS;
  assign unmatch_read = rd_hit && bus_req.addr == OFS_UNMATCH;

  // Configuration; freezes clear the enables and win over a host write.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      config_reg <= CFG_RESET;
    else if (clk_en)
    begin
      if (wr_hit && bus_req.addr == OFS_CONFIG)
        config_reg <= bus_req.wdata[CFG_WIDTH-1:0];
      if (events.tx_overflow)
        config_reg[CFG_TX_EN] <= 1'b0;
      if (events.rx_overflow)
        config_reg[CFG_RX_EN] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_mask              <= '0;
      aging_reload_value      <= '0;
      aging_cycle_limit       <= '0;
      tx_done_ring_quiet_size <= '0;
      tx_done_ring_irq_size   <= '0;
      rx_done_ring_quiet_size <= '0;
      rx_done_ring_irq_size   <= '0;
    end
    else if (wr_hit)
    begin
      unique case (bus_req.addr)
        OFS_MASK:
          event_mask <= bus_req.wdata & MASK_IMPL;
        OFS_AGING:
        begin
          aging_reload_value <= bus_req.wdata[31:16];
          aging_cycle_limit  <= {1'b0, bus_req.wdata[AGING_CNT_W-1:0]};
        end
        OFS_TX_RINGS:
        begin
          tx_done_ring_quiet_size <= {3'h0, bus_req.wdata[16+TX_RING_W-1:16]};
          tx_done_ring_irq_size   <= {3'h0, bus_req.wdata[TX_RING_W-1:0]};
        end
        OFS_RX_RINGS:
        begin
          rx_done_ring_quiet_size <= {6'h00, bus_req.wdata[16+RX_RING_W-1:16]};
          rx_done_ring_irq_size   <= {6'h00, bus_req.wdata[RX_RING_W-1:0]};
        end
        default:
        begin
        end
      endcase
    end
  end

  // Bus width strap is caught once it has crossed both flops after reset release.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_sync <= 2'h0;
      strap_fill <= 2'h0;
    end
    else if (clk_en)
    begin
      strap_sync <= {strap_sync[0], bus64_strap};
      strap_fill <= {strap_fill[0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus64_latched <= 1'b0;
      strap_taken   <= 1'b0;
    end
    else if (clk_en && strap_fill[1] && !strap_taken)
    begin
      bus64_latched <= strap_sync[1];
      strap_taken   <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pci_status <= '0;
    else if (clk_en)
      pci_status <= bus_status;
  end

  assign capture = unmatched_valid && (path_disabled || out_of_range || chan_off);

  always_comb
  begin
    set_bits = '0;
    set_bits[ST_TX_DONE]   = events.tx_done;
    set_bits[ST_SENT_WRAP] = events.sent_wrap;
    set_bits[ST_RCVD_WRAP] = events.rcvd_wrap;
    set_bits[ST_DISC_WRAP] = events.discard_wrap;
    set_bits[ST_PROT_WRAP] = events.protocol_wrap;
    set_bits[ST_HDR_WRAP]  = events.hdr_err_wrap;
    set_bits[ST_UNMATCH]   = capture
                             && (unmatch_read || !unmatched_header_capture[UH_VALID]);
    set_bits[ST_RX_DONE]   = events.rx_done;
    set_bits[ST_TRANSMIT_FREEZE]    = events.tx_overflow;
    set_bits[ST_RECEIVE_FREEZE]    = events.rx_overflow;
  end

  // A set arriving with the clearing read wins, so no event is lost.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      event_status <= '0;
    else if (clk_en)
    begin
      if (status_read)
        event_status <= set_bits;
      else
        event_status <= event_status | set_bits;
    end
  end

  // Only the first unmatched header is kept until the host reads it.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      unmatched_header_capture <= '0;
    else if (clk_en)
    begin
      if (capture && (unmatch_read || !unmatched_header_capture[UH_VALID]))
        unmatched_header_capture <= {1'b1, unmatched_hdr & UH_FIELD_MASK};
      else if (unmatch_read)
        unmatched_header_capture <= '0;
    end
  end

  assign status_word = {pci_status, 5'h00, bus64_latched, event_status};

  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (bus_req.addr)
      OFS_CONFIG:   next_rdata = {18'h00000, config_reg};
      OFS_STATUS:   next_rdata = status_word;
      OFS_MASK:     next_rdata = event_mask;
      OFS_AGING:    next_rdata = {aging_reload_value, aging_cycle_limit};
      OFS_UNMATCH:  next_rdata = {3'h0, unmatched_header_capture};
      OFS_TX_RINGS: next_rdata = {tx_done_ring_quiet_size, tx_done_ring_irq_size};
      OFS_RX_RINGS: next_rdata = {rx_done_ring_quiet_size, rx_done_ring_irq_size};
      default:      next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata <= '0;
    else if (rd_hit)
      bus_rdata <= next_rdata;
  end

  // Datapath steering outputs, all registered.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_memory_address <= '0;
      host_fetch_grant       <= 1'b0;
      cell_accept            <= 1'b0;
      big_endian             <= 1'b0;
      tx_done_irq_pulse      <= 1'b0;
      irq                    <= 1'b0;
    end
    else if (clk_en)
    begin
      control_memory_address <= cm_addr_in;
      if (config_reg[CFG_SMALL_MAP])
      begin
        control_memory_address[13] <= cm_addr_in[13] | cm_addr_in[14];
        control_memory_address[12] <= cm_addr_in[12] | cm_addr_in[14];
      end
      host_fetch_grant  <= host_fetch_req && config_reg[CFG_TX_EN];
      cell_accept       <= cell_arrive && config_reg[CFG_RX_EN];
      big_endian        <= config_reg[CFG_ORDER_LO+1:CFG_ORDER_LO] == ORDER_BIG;
      tx_done_irq_pulse <= events.tx_done
                           && (tx_packet_end || !config_reg[CFG_GRAN]);
      irq               <= |(status_word & event_mask);
    end
  end

  scsr_aging_timer u_aging (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (clk_en),
    .enable      (config_reg[CFG_AGING_EN]),
    .reload      (aging_reload_value),
    .cycle_limit (aging_cycle_limit[AGING_CNT_W-1:0]),
    .expire      (aging_expire),
    .channel     (aging_chan_q)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aging_tick    <= 1'b0;
      aging_channel <= '0;
    end
    else if (clk_en)
    begin
      aging_tick    <= aging_expire;
      aging_channel <= aging_chan_q;
    end
  end

  scsr_ring_ptr #(.W(TX_RING_W)) u_txq (
    .mclk (mclk), .rst_n (rst_n), .ce (clk_en), .advance (tx_ring_quiet_adv),
    .size_code (tx_done_ring_quiet_size[TX_RING_W-1:0]), .ptr (tx_quiet_ptr)
  );
  scsr_ring_ptr #(.W(TX_RING_W)) u_txi (
    .mclk (mclk), .rst_n (rst_n), .ce (clk_en), .advance (tx_ring_irq_adv),
    .size_code (tx_done_ring_irq_size[TX_RING_W-1:0]), .ptr (tx_irq_ptr)
  );
  scsr_ring_ptr #(.W(RX_RING_W)) u_rxq (
    .mclk (mclk), .rst_n (rst_n), .ce (clk_en), .advance (rx_ring_quiet_adv),
    .size_code (rx_done_ring_quiet_size[RX_RING_W-1:0]), .ptr (rx_quiet_ptr)
  );
  scsr_ring_ptr #(.W(RX_RING_W)) u_rxi (
    .mclk (mclk), .rst_n (rst_n), .ce (clk_en), .advance (rx_ring_irq_adv),
    .size_code (rx_done_ring_irq_size[RX_RING_W-1:0]), .ptr (rx_irq_ptr)
  );
endmodule // scsr_regs
`default_nettype wire

// file: tb/scsr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scsr_regs_asserts
  import scsr_pkg::*;
#(
  parameter int CM_ADDR_W = 15
)(
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  input wire scsr_bus_req_t        bus_req,
  input wire logic [31:0]          bus_rdata,
  input wire logic [15:0]          bus_status,
  input wire scsr_events_t         events,
  input wire logic                 unmatched_valid,
  input wire logic [CM_ADDR_W-1:0] cm_addr_in,
  input wire logic [CM_ADDR_W-1:0] control_memory_address,
  input wire logic                 host_fetch_req,
  input wire logic                 host_fetch_grant,
  input wire logic                 cell_arrive,
  input wire logic                 cell_accept,
  input wire logic                 tx_done_irq_pulse,
  input wire logic                 tx_ring_irq_adv,
  input wire logic [TX_RING_W-1:0] tx_irq_ptr,
  input wire logic                 rx_ring_quiet_adv,
  input wire logic [RX_RING_W-1:0] rx_quiet_ptr
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_stat_rd;
    clk_en && bus_req.sel && !bus_req.wr && bus_req.addr == OFS_STATUS;
  endsequence
  // A quiet read sees no event or capture that could set a bit in the same cycle.
  sequence s_quiet_rd;
    s_stat_rd ##0 (events == '0 && !unmatched_valid);
  endsequence

  property p_grant;
    host_fetch_grant |-> $past(host_fetch_req);
  endproperty
  a_grant: assert property (p_grant) else $error("fetch grant without request");
  property p_accept;
    cell_accept |-> $past(cell_arrive);
  endproperty
  a_accept: assert property (p_accept) else $error("cell accepted without arrival");
  property p_cma;
    $past(clk_en) |-> control_memory_address[11:0] == $past(cm_addr_in[11:0])
      && control_memory_address[14] == $past(cm_addr_in[14])
      && (control_memory_address[13:12] == $past(cm_addr_in[13:12])
      || (control_memory_address[13:12] == 2'h3 && $past(cm_addr_in[14])));
  endproperty
  a_cma: assert property (p_cma) else $error("control memory address mangled");
  property p_txirq;
    tx_done_irq_pulse |-> $past(events.tx_done);
  endproperty
  a_txirq: assert property (p_txirq) else $error("completion pulse without tx done");
  property p_mirror;
    s_stat_rd |=> bus_rdata[31:16] == $past(bus_status, 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("bus status not mirrored");
  property p_cor;
    s_quiet_rd ##1 (events == '0 && !unmatched_valid) ##1 s_quiet_rd
      |=> bus_rdata[ST_EVENTS-1:0] == '0;
  endproperty
  a_cor: assert property (p_cor) else $error("event bits survived a read");
  property p_tx_ptr;
    tx_irq_ptr != $past(tx_irq_ptr) |-> tx_irq_ptr == '0
      || ($past(tx_ring_irq_adv) && tx_irq_ptr == $past(tx_irq_ptr) + 1'b1);
  endproperty
  a_tx_ptr: assert property (p_tx_ptr) else $error("tx ring pointer jumped");
  property p_rx_ptr;
    rx_quiet_ptr != $past(rx_quiet_ptr) |-> rx_quiet_ptr == '0
      || ($past(rx_ring_quiet_adv) && rx_quiet_ptr == $past(rx_quiet_ptr) + 1'b1);
  endproperty
  a_rx_ptr: assert property (p_rx_ptr) else $error("rx ring pointer jumped");
endmodule // scsr_regs_asserts
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import scsr_pkg::*;
;
  logic          mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, bus64_strap = 1'b1;
  scsr_bus_req_t bus_req = '0;
  scsr_events_t  events = '0;
  logic [15:0]   bus_status = 16'hA5C3;
  logic [27:0]   unmatched_hdr = '0;
  logic [14:0]   cm_addr_in = '0;
  logic          tx_packet_end = 1'b0, unmatched_valid = 1'b0, path_disabled = 1'b0;
  logic          out_of_range = 1'b0, chan_off = 1'b0, host_fetch_req = 1'b0;
  logic          cell_arrive = 1'b0, tqa = 1'b0, tia = 1'b0, rqa = 1'b0, ria = 1'b0;
  logic [31:0]   bus_rdata, d;
  logic [14:0]   control_memory_address, aging_channel, last;
  logic          host_fetch_grant, cell_accept, big_endian, tx_done_irq_pulse, aging_tick, irq;
  logic [12:0]   tx_quiet_ptr, tx_irq_ptr;
  logic [9:0]    rx_quiet_ptr, rx_irq_ptr;
  int            err_count = 0, check_count = 0, n;
  logic [31:0]   base;
  int            sb[9] = '{1, 2, 3, 4, 5, 9, 8, 0, 7};

  scsr_regs uut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus64_strap(bus64_strap), .bus_status(bus_status),
    .events(events), .tx_packet_end(tx_packet_end), .unmatched_valid(unmatched_valid),
    .path_disabled(path_disabled), .out_of_range(out_of_range), .chan_off(chan_off),
    .unmatched_hdr(unmatched_hdr), .cm_addr_in(cm_addr_in), .host_fetch_req(host_fetch_req),
    .cell_arrive(cell_arrive), .tx_ring_quiet_adv(tqa), .tx_ring_irq_adv(tia),
    .rx_ring_quiet_adv(rqa), .rx_ring_irq_adv(ria), .control_memory_address(control_memory_address),
    .host_fetch_grant(host_fetch_grant), .cell_accept(cell_accept), .big_endian(big_endian),
    .tx_done_irq_pulse(tx_done_irq_pulse), .aging_tick(aging_tick), .aging_channel(aging_channel),
    .tx_quiet_ptr(tx_quiet_ptr), .tx_irq_ptr(tx_irq_ptr), .rx_quiet_ptr(rx_quiet_ptr),
    .rx_irq_ptr(rx_irq_ptr), .irq(irq));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask

  // Each access drops sel after one edge, so reads never repeat a clear by accident.
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(negedge mclk);
    bus_req = '{sel: 1'b1, wr: w, addr: a, wdata: wd};
    @(negedge mclk);
    bus_req = '0;
    d = bus_rdata;
  endtask

  task automatic pulse_ev(input int i);
    @(negedge mclk);
    events = scsr_events_t'(9'h1 << i);
    @(negedge mclk);
    events = '0;
  endtask

  task automatic t_reset;
    logic [5:0] ofs[6] = '{OFS_CONFIG, OFS_MASK, OFS_AGING, OFS_UNMATCH, OFS_TX_RINGS, 6'h3C};
    base = {bus_status, 5'h0, bus64_strap, 10'h0};
    foreach (ofs[i])
    begin
      acc(1'b0, ofs[i], 32'h0);
      chk("reset_value", d, 32'h0);
    end
    chk("big_endian", 32'(big_endian), 32'h0);
    acc(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk("status", d, base);
  endtask

  task automatic t_config;
    host_fetch_req = 1'b1;
    cell_arrive = 1'b1;
    cm_addr_in = 15'h4123;
    cyc(2);
    chk("grant_off", 32'(host_fetch_grant), 32'h0);
    chk("accept_off", 32'(cell_accept), 32'h0);
    acc(1'b1, OFS_CONFIG, (32'h1 << CFG_TX_EN) | (32'h1 << CFG_RX_EN) | (32'h1 << CFG_SMALL_MAP));
    cyc(1);
    chk("grant_on", 32'(host_fetch_grant), 32'h1);
    chk("accept_on", 32'(cell_accept), 32'h1);
    chk("cm_small", 32'(control_memory_address), 32'h7123);
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, OFS_CONFIG, 32'(c) << CFG_ORDER_LO);
      cyc(1);
      chk("big_endian", 32'(big_endian), 32'(c == 1));
      chk("grant_drop", 32'(host_fetch_grant), 32'h0);
    end
    chk("cm_full", 32'(control_memory_address), 32'h4123);
    host_fetch_req = 1'b0;
    cell_arrive = 1'b0;
    cm_addr_in = '0;
  endtask

  task automatic t_freeze;
    acc(1'b1, OFS_CONFIG, (32'h1 << CFG_TX_EN) | (32'h1 << CFG_RX_EN));
    pulse_ev(6);
    acc(1'b0, OFS_CONFIG, 32'h0);
    chk("cfg_txfrz", d, 32'h1 << CFG_RX_EN);
    pulse_ev(5);
    acc(1'b0, OFS_CONFIG, 32'h0);
    chk("cfg_rxfrz", d, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk("status_frz", d, base | 32'h300);
  endtask

  task automatic t_events;
    acc(1'b1, OFS_MASK, 32'h3FF);
    for (int i = 0; i < 9; i++)
    begin
      pulse_ev(i);
      cyc(1);
      chk("irq_set", 32'(irq), 32'h1);
      acc(1'b0, OFS_STATUS, 32'h0);
      chk("status_ev", d, base | (32'h1 << sb[i]));
      acc(1'b0, OFS_STATUS, 32'h0);
      chk("status_cor", d, base);
      chk("irq_clr", 32'(irq), 32'h0);
    end
    acc(1'b1, OFS_MASK, 32'h0);
    pulse_ev(0);
    cyc(1);
    chk("irq_masked", 32'(irq), 32'h0);
  endtask

  task automatic t_txirq;
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, OFS_CONFIG, 32'(i != 0) << CFG_GRAN);
      @(negedge mclk);
      events.tx_done = 1'b1;
      tx_packet_end = (i == 2);
      @(negedge mclk);
      chk("tx_done_irq", 32'(tx_done_irq_pulse), 32'(i != 1));
      events = '0;
      tx_packet_end = 1'b0;
    end
    acc(1'b0, OFS_STATUS, 32'h0);
  endtask

  task automatic t_unmatch;
    for (int r = 0; r < 3; r++)
    begin
      @(negedge mclk);
      unmatched_valid = 1'b1;
      path_disabled = (r == 0);
      out_of_range = (r == 1);
      chan_off = (r == 2);
      unmatched_hdr = 28'h9876FFF ^ (28'h10000 << r);
      @(negedge mclk);
      unmatched_hdr = 28'h5432000;
      @(negedge mclk);
      unmatched_valid = 1'b0;
      acc(1'b0, OFS_UNMATCH, 32'h0);
      chk("unmatched", d, {4'h1, (28'h9876C00 ^ (28'h10000 << r))});
      acc(1'b0, OFS_STATUS, 32'h0);
      chk("status_uh", d, base | 32'h40);
      acc(1'b0, OFS_UNMATCH, 32'h0);
      chk("unmatched_cor", d, 32'h0);
    end
  endtask

  task automatic t_rings;
    acc(1'b1, OFS_TX_RINGS, 32'h00070003);
    acc(1'b1, OFS_RX_RINGS, 32'h00070001);
    @(negedge mclk);
    tia = 1'b1;
    rqa = 1'b1;
    tqa = 1'b1;
    ria = 1'b1;
    for (int k = 1; k < 10; k++)
    begin
      @(negedge mclk);
      chk("tx_irq_ptr", 32'(tx_irq_ptr), 32'(k % 4));
      chk("rx_quiet_ptr", 32'(rx_quiet_ptr), 32'(k % 8));
      chk("tx_quiet_ptr", 32'(tx_quiet_ptr), 32'(k % 8));
      chk("rx_irq_ptr", 32'(rx_irq_ptr), 32'(k % 2));
    end
    tia = 1'b0;
    rqa = 1'b0;
    tqa = 1'b0;
    ria = 1'b0;
  endtask

  task automatic t_aging;
    acc(1'b1, OFS_AGING, 32'h00031000);
    for (int e = 0; e < 2; e++)
    begin
      acc(1'b1, OFS_CONFIG, 32'(e) << CFG_AGING_EN);
      n = 0;
      repeat (40)
      begin
        @(negedge mclk);
        if (aging_tick === 1'b1)
        begin
          if (n > 0)
            chk("aging_channel", 32'(aging_channel), 32'(last + 15'h1));
          last = aging_channel;
          n++;
        end
      end
      chk("aging_ticks", 32'(n > 2), 32'(e));
    end
  endtask

  task automatic t_swreset;
    acc(1'b1, OFS_MASK, 32'h3FF);
    bus_status = 16'h5A3C;
    base[31:16] = bus_status;
    acc(1'b1, OFS_SW_RESET, 32'h0);
    cyc(12);
    acc(1'b0, OFS_MASK, 32'h0);
    chk("mask_swrst", d, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk("status_swrst", d, base);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(2);
    reset_n = 1'b1;
    cyc(3);
    t_reset;
    t_config;
    t_freeze;
    t_events;
    t_txirq;
    t_unmatch;
    t_rings;
    t_aging;
    t_swreset;
    tally_and_finish;
  end

  // The whole sequence needs a few hundred cycles; this cuts a hang far beyond that.
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule // testbench

bind scsr_regs scsr_regs_asserts #(.CM_ADDR_W(CM_ADDR_W)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .clk_en(clk_en), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_status(bus_status),
  .events(events), .unmatched_valid(unmatched_valid), .cm_addr_in(cm_addr_in),
  .control_memory_address(control_memory_address), .host_fetch_req(host_fetch_req),
  .host_fetch_grant(host_fetch_grant), .cell_arrive(cell_arrive), .cell_accept(cell_accept),
  .tx_done_irq_pulse(tx_done_irq_pulse), .tx_ring_irq_adv(tx_ring_irq_adv),
  .tx_irq_ptr(tx_irq_ptr), .rx_ring_quiet_adv(rx_ring_quiet_adv), .rx_quiet_ptr(rx_quiet_ptr));
`default_nettype wire
